// ---- logic/fslp_if.sv ----
`timescale 1ns/1ps
interface fslp_if;
    logic        start;
    logic        busy;
    logic        fire;
    modport ctl (output start, input busy, input fire);
    modport eng (input start, output busy, output fire);
endinterface

// ---- logic/fslp_pkg.sv ----
package fslp_pkg;
    // ***************************************************************
    // register file addresses
    // ***************************************************************
    localparam logic [11:0] FSLP_CTL_ADDR   = 12'hFF8;
    localparam logic [11:0] FSLP_PAGE_ADDR  = 12'hFF9;
    // ***************************************************************
    // control register command bytes
    // ***************************************************************
    localparam logic [7:0]  FSLP_CMD_RESET   = 8'h00;
    localparam logic [7:0]  FSLP_CMD_PROTECT = 8'h5E;
    localparam logic [7:0]  FSLP_CMD_UNLOCK1 = 8'hA1;
    localparam logic [7:0]  FSLP_CMD_UNLOCK2 = 8'hB2;
    localparam logic [7:0]  FSLP_CMD_PAGE_ER = 8'hC3;
    localparam logic [7:0]  FSLP_CMD_MASS_ER = 8'hD4;
    // ***************************************************************
    // reset values and field layout
    // ***************************************************************
    localparam logic [7:0]  FSLP_LOCK_RESET = 8'h00;
    localparam logic [7:0]  FSLP_PAGE_RESET = 8'h00;
    localparam logic [7:0]  FSLP_ERASED     = 8'hFF;
    localparam int          FSLP_ADDR_W     = 13;
    localparam int          FSLP_PAGE_LSB   = 9;
    localparam int          FSLP_SECT_LSB   = 10;
    localparam int          FSLP_ST_OPEN    = 0;
    localparam int          FSLP_ST_BUSY    = 1;
    localparam int          FSLP_ST_PSEL    = 2;
    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int          FSLP_CLK_NS     = 5;
    localparam int          FSLP_PROG_NS    = 100;
    localparam logic [7:0]  FSLP_PROG_CYC   = 8'((FSLP_PROG_NS + FSLP_CLK_NS - 1) / FSLP_CLK_NS);
    // ***************************************************************
    // unlock state
    // ***************************************************************
    typedef enum {FSLP_LOCKED, FSLP_HALF, FSLP_OPEN} fslp_lock_e;
endpackage

// ---- logic/fslp_prog_timer.sv ----
`timescale 1ns/1ps
module fslp_prog_timer
    import fslp_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic en_in,
    fslp_if.eng       bus
);
    logic [7:0] count;
    logic       busy_q;

    // fire marks the last cycle of a byte program
    assign bus.busy = busy_q;
    assign bus.fire = busy_q && (count == 8'h00);

    // program time counter; a start while busy is ignored
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_q <= 1'b0;
            count  <= 8'h00;
        end else if (en_in) begin
            if (bus.start && !busy_q) begin
                busy_q <= 1'b1;
                count  <= FSLP_PROG_CYC - 8'h01;
            end else if (bus.fire) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                count  <= count - 8'h01;
            end
        end
    end
endmodule // fslp_prog_timer

// ---- logic/fslp_top.sv ----
// How it works
// - reset clears every sector lock bit; only reset ever clears one
// - lock register writes OR in ones; written zeros change nothing
// - a locked sector refuses byte program and erase
// - control byte 5EH maps the page select address onto the lock register
// - any other control byte maps the page select register back
// - software: 00H, 5EH, access lock at FF9H, then 00H again
// - byte program only on the active page and only when unlocked
// - programming only clears bits; the written byte is new AND old
// - byte program accepted from debug writes and processor stores
// - processor stalls while a byte programs; clock keeps running
// - after a byte program the page stays unlocked for more writes
// - any control byte except erase commands relocks the flash
`timescale 1ns/1ps
module fslp_top
    import fslp_pkg::*;
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic                   en_in,
    input  wire logic [11:0]            reg_addr_in,
    input  wire logic [7:0]             reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [7:0]             reg_rdata_out,
    input  wire logic                   program_memory_store_in,
    input  wire logic                   program_memory_store_incr_in,
    input  wire logic [FSLP_ADDR_W-1:0] cpu_addr_in,
    input  wire logic [7:0]             cpu_data_in,
    input  wire logic                   dbg_wr_in,
    input  wire logic [FSLP_ADDR_W-1:0] dbg_addr_in,
    input  wire logic [7:0]             dbg_data_in,
    input  wire logic [7:0]             flash_rdata_in,
    output logic                        cpu_stall_out,
    output logic      [FSLP_ADDR_W-1:0] flash_addr_out,
    output logic      [7:0]             flash_wdata_out,
    output logic                        flash_prog_out,
    output logic                        flash_page_erase_out,
    output logic                        flash_mass_erase_out,
    output logic                        op_refused_out
);
    // ***************************************************************
    // state
    // ***************************************************************
    fslp_lock_e             state;
    fslp_lock_e             next_state;
    logic [7:0]             sector_write_lock;
    logic [7:0]             page_sel;
    logic                   psel;
    logic [7:0]             req_data;
    fslp_if                 tmr ();

    fslp_prog_timer u_timer (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .en_in  (en_in),
        .bus    (tmr.eng)
    );

    // ***************************************************************
    // decode
    // ***************************************************************
    wire                   ctl_wr    = reg_wr_in && (reg_addr_in == FSLP_CTL_ADDR);
    wire                   page_wr   = reg_wr_in && (reg_addr_in == FSLP_PAGE_ADDR);
    wire                   lock_wr   = page_wr && psel;
    wire                   sel_wr    = page_wr && !psel;
    wire                   is_page   = reg_wdata_in == FSLP_CMD_PAGE_ER;
    wire                   is_mass   = reg_wdata_in == FSLP_CMD_MASS_ER;
    // debug writes win over a processor store in the same cycle
    wire                   cpu_req   = program_memory_store_in || program_memory_store_incr_in;
    wire                   req       = dbg_wr_in || cpu_req;
    wire [FSLP_ADDR_W-1:0] req_addr  = dbg_wr_in ? dbg_addr_in : cpu_addr_in;
    wire [7:0]             req_wd    = dbg_wr_in ? dbg_data_in : cpu_data_in;
    wire [3:0]             req_page  = req_addr[FSLP_ADDR_W-1:FSLP_PAGE_LSB];
    wire [2:0]             req_sect  = req_addr[FSLP_ADDR_W-1:FSLP_SECT_LSB];
    wire [2:0]             sel_sect  = page_sel[3:1];
    wire                   is_open   = state == FSLP_OPEN;
    wire                   on_page   = page_sel == {4'h0, req_page};
    wire                   req_ok    = is_open && on_page && !sector_write_lock[req_sect];
    wire                   start_ok  = req && !tmr.busy && req_ok;
    wire                   req_bad   = req && !tmr.busy && !req_ok;
    wire                   pg_ok     = is_open && !sector_write_lock[sel_sect];
    wire                   ms_ok     = is_open && (sector_write_lock == FSLP_LOCK_RESET);
    wire                   do_page   = ctl_wr && is_page && pg_ok && !tmr.busy;
    wire                   do_mass   = ctl_wr && is_mass && ms_ok && !tmr.busy;
    wire                   er_bad    = ctl_wr && (is_page || is_mass) && !do_page && !do_mass;
    wire [7:0]             status    = {5'h00, psel, tmr.busy, is_open};
    wire [7:0]             rd_mux    = (reg_addr_in == FSLP_CTL_ADDR) ? status :
                                       (reg_addr_in == FSLP_PAGE_ADDR) ?
                                       (psel ? sector_write_lock : page_sel) : 8'h00;

    assign tmr.start = start_ok;

    // ***************************************************************
    // unlock sequence
    // ***************************************************************
    always_comb begin
        next_state = state;
        if (ctl_wr) begin
            case (state)
                FSLP_LOCKED: begin
                    next_state = (reg_wdata_in == FSLP_CMD_UNLOCK1) ? FSLP_HALF : FSLP_LOCKED;
                end
                FSLP_HALF: begin
                    next_state = (reg_wdata_in == FSLP_CMD_UNLOCK2) ? FSLP_OPEN : FSLP_LOCKED;
                end
                default: begin
                    // erase commands keep the page open, all else relocks
                    next_state = (is_page || is_mass) ? FSLP_OPEN : FSLP_LOCKED;
                end
            endcase
        end
    end

    // byte programs never touch state, so the page stays open
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= FSLP_LOCKED;
        end else if (en_in) begin
            state <= next_state;
        end
    end

    // ***************************************************************
    // lock register and page select
    // ***************************************************************
    // the lock and page select share one address; psel steers it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sector_write_lock <= FSLP_LOCK_RESET;
            page_sel          <= FSLP_PAGE_RESET;
            psel              <= 1'b0;
        end else if (en_in) begin
            if (lock_wr) begin
                sector_write_lock <= sector_write_lock | reg_wdata_in;
            end
            if (sel_wr) begin
                page_sel <= reg_wdata_in;
            end
            if (ctl_wr) begin
                psel <= (reg_wdata_in == FSLP_CMD_PROTECT);
            end
        end
    end

    // ***************************************************************
    // flash port and stall
    // ***************************************************************
    // address and data stay put while programming so the old byte is stable
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flash_addr_out       <= '0;
            req_data             <= FSLP_ERASED;
            flash_wdata_out      <= FSLP_ERASED;
            flash_prog_out       <= 1'b0;
            flash_page_erase_out <= 1'b0;
            flash_mass_erase_out <= 1'b0;
            cpu_stall_out        <= 1'b0;
            op_refused_out       <= 1'b0;
            reg_rdata_out        <= 8'h00;
        end else if (en_in) begin
            if (start_ok) begin
                flash_addr_out <= req_addr;
                req_data       <= req_wd;
            end else if (do_page) begin
                flash_addr_out <= {page_sel[3:0], 9'h000};
            end
            if (tmr.fire) begin
                flash_wdata_out <= req_data & flash_rdata_in;
            end
            flash_prog_out       <= tmr.fire;
            flash_page_erase_out <= do_page;
            flash_mass_erase_out <= do_mass;
            cpu_stall_out        <= start_ok || (cpu_stall_out && !tmr.fire);
            op_refused_out       <= req_bad || er_bad;
            if (reg_rd_in) begin
                reg_rdata_out <= rd_mux;
            end
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    localparam int PMIN = 12; // fewest cycles allowed to the pulse after the first eight of stall; the pulse comes 13 later
    localparam int PMAX = 22;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in || !en_in);

    property p_lock_sticky;
        (sector_write_lock & $past(sector_write_lock)) == $past(sector_write_lock);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared without reset");

    property p_lock_or;
        en_in && lock_wr |=> sector_write_lock == ($past(sector_write_lock) | $past(reg_wdata_in));
    endproperty
    a_lock_or: assert property (p_lock_or)
        else $error("lock write not ORed");

    property p_psel_on;
        en_in && ctl_wr && reg_wdata_in == FSLP_CMD_PROTECT |=> psel;
    endproperty
    a_psel_on: assert property (p_psel_on)
        else $error("protect select missing");

    property p_psel_off;
        en_in && ctl_wr && reg_wdata_in != FSLP_CMD_PROTECT |=> !psel ##0 !lock_wr;
    endproperty
    a_psel_off: assert property (p_psel_off)
        else $error("protect select not dropped");

    property p_prot_refused;
        en_in && req && !tmr.busy && sector_write_lock[req_sect]
            |=> op_refused_out && !cpu_stall_out;
    endproperty
    a_prot_refused: assert property (p_prot_refused)
        else $error("protected sector accepted");

    property p_lock_refused;
        en_in && req && !tmr.busy && !is_open |=> op_refused_out ##0 !flash_prog_out[*2];
    endproperty
    a_lock_refused: assert property (p_lock_refused)
        else $error("program accepted while locked");

    property p_clear_only;
        flash_prog_out |-> (flash_wdata_out & ~$past(flash_rdata_in)) == 8'h00;
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("program set a bit");

    property p_stall;
        en_in && start_ok |=> cpu_stall_out[*8] ##[PMIN:PMAX] flash_prog_out;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall or program time wrong");

    property p_stay_open;
        en_in && tmr.fire && !ctl_wr |=> state == FSLP_OPEN;
    endproperty
    a_stay_open: assert property (p_stay_open)
        else $error("page relocked after program");

    property p_relock;
        en_in && ctl_wr && is_open && !is_page && !is_mass |=> state == FSLP_LOCKED;
    endproperty
    a_relock: assert property (p_relock)
        else $error("flash not relocked");

    c_program: cover property (start_ok ##[1:PMAX] flash_prog_out);
    c_protect: cover property (lock_wr ##1 sector_write_lock != FSLP_LOCK_RESET);
    c_refused: cover property (req_bad && tmr.busy == 1'b0);
    c_erase:   cover property (do_page);
endmodule // fslp_top

// ---- sim/fslp_top_tb_top.sv ----
`timescale 1ns/1ps
module fslp_top_tb_top;
    import fslp_pkg::*;
    // ***************************************************************
    // stimulus and observed signals
    // ***************************************************************
    logic                   clk_in, rst_in, en_in, reg_wr_in, reg_rd_in;
    logic                   program_memory_store_in, program_memory_store_incr_in, dbg_wr_in;
    logic [11:0]            reg_addr_in;
    logic [7:0]             reg_wdata_in, cpu_data_in, dbg_data_in, flash_rdata_in;
    logic [FSLP_ADDR_W-1:0] cpu_addr_in, dbg_addr_in;
    logic [7:0]             reg_rdata_out, flash_wdata_out;
    logic [FSLP_ADDR_W-1:0] flash_addr_out;
    logic                   cpu_stall_out, flash_prog_out, op_refused_out;
    logic                   flash_page_erase_out, flash_mass_erase_out;
    int                     miscompares = 0;
    int                     n_tests = 0;

    fslp_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .en_in(en_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .program_memory_store_in(program_memory_store_in),
        .program_memory_store_incr_in(program_memory_store_incr_in),
        .cpu_addr_in(cpu_addr_in), .cpu_data_in(cpu_data_in), .dbg_wr_in(dbg_wr_in),
        .dbg_addr_in(dbg_addr_in), .dbg_data_in(dbg_data_in), .flash_rdata_in(flash_rdata_in),
        .cpu_stall_out(cpu_stall_out), .flash_addr_out(flash_addr_out),
        .flash_wdata_out(flash_wdata_out), .flash_prog_out(flash_prog_out),
        .flash_page_erase_out(flash_page_erase_out),
        .flash_mass_erase_out(flash_mass_erase_out), .op_refused_out(op_refused_out));

    // free-running 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // ***************************************************************
    // shared tasks
    // ***************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one-cycle write strobe; returns just after the taking edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    // read and compare; data is registered at the taking edge
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk({8'h00, reg_rdata_out}, {8'h00, e});
    endtask

    task automatic unlock();
        wr(FSLP_CTL_ADDR, FSLP_CMD_UNLOCK1);
        wr(FSLP_CTL_ADDR, FSLP_CMD_UNLOCK2);
    endtask

    // src 0 store, 1 incrementing store, 2 debug write; old is the array byte
    task automatic prog(input int src, input logic [12:0] a, input logic [7:0] d,
                        input logic [7:0] old, input logic ok);
        int at;
        at = 0;
        @(posedge clk_in);
        flash_rdata_in <= old;
        cpu_addr_in <= a;
        cpu_data_in <= d;
        dbg_addr_in <= a;
        dbg_data_in <= d;
        program_memory_store_in <= (src == 0);
        program_memory_store_incr_in <= (src == 1);
        dbg_wr_in <= (src == 2);
        @(posedge clk_in);
        program_memory_store_in <= 1'b0;
        program_memory_store_incr_in <= 1'b0;
        dbg_wr_in <= 1'b0;
        #1;
        chk({15'h0, cpu_stall_out}, {15'h0, ok});
        chk({15'h0, op_refused_out}, {15'h0, !ok});
        // watch a window a little longer than the program time
        for (int i = 1; i <= 24; i++) begin
            @(posedge clk_in);
            #1;
            if (i == 10) chk({15'h0, cpu_stall_out}, {15'h0, ok});
            if (flash_prog_out === 1'b1) begin
                at = i;
                chk({8'h00, flash_wdata_out}, {8'h00, d & old});
                chk({3'h0, flash_addr_out}, {3'h0, a});
                chk({15'h0, cpu_stall_out}, 16'h0);
            end
        end
        chk(16'(at), ok ? 16'h0014 : 16'h0000);
    endtask
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic s_reset_values();
        wr(FSLP_CTL_ADDR, FSLP_CMD_RESET);
        wr(FSLP_CTL_ADDR, FSLP_CMD_PROTECT);
        rdc(FSLP_PAGE_ADDR, 8'h00);
        wr(FSLP_CTL_ADDR, FSLP_CMD_RESET);
        rdc(FSLP_CTL_ADDR, 8'h00);
    endtask

    task automatic s_program();
        wr(FSLP_PAGE_ADDR, 8'h02);
        prog(0, 13'h0410, 8'h3C, 8'hF0, 1'b0);
        unlock();
        rdc(FSLP_CTL_ADDR, 8'h01);
        wr(FSLP_CTL_ADDR, FSLP_CMD_MASS_ER);
        chk({15'h0, flash_mass_erase_out}, 16'h1);
        prog(0, 13'h0410, 8'h3C, 8'hF0, 1'b1);
        prog(1, 13'h0411, 8'h0F, 8'hFF, 1'b1);
        prog(2, 13'h05FF, 8'hA5, 8'h5A, 1'b1);
        prog(0, 13'h0600, 8'h00, 8'hFF, 1'b0);
        wr(FSLP_CTL_ADDR, FSLP_CMD_RESET);
        rdc(FSLP_CTL_ADDR, 8'h00);
        prog(2, 13'h0410, 8'h00, 8'hFF, 1'b0);
    endtask

    task automatic s_protect();
        wr(FSLP_CTL_ADDR, FSLP_CMD_PROTECT);
        wr(FSLP_PAGE_ADDR, 8'h01);
        wr(FSLP_PAGE_ADDR, 8'h00);
        rdc(FSLP_PAGE_ADDR, 8'h01);
        wr(FSLP_PAGE_ADDR, 8'h80);
        rdc(FSLP_PAGE_ADDR, 8'h81);
        wr(FSLP_CTL_ADDR, FSLP_CMD_RESET);
        rdc(FSLP_PAGE_ADDR, 8'h02);
        unlock();
        wr(FSLP_CTL_ADDR, FSLP_CMD_PAGE_ER);
        chk({15'h0, flash_page_erase_out}, 16'h1);
        chk({3'h0, flash_addr_out}, 16'h0400);
        wr(FSLP_CTL_ADDR, FSLP_CMD_MASS_ER);
        chk({15'h0, op_refused_out}, 16'h1);
        chk({15'h0, flash_mass_erase_out}, 16'h0);
        prog(0, 13'h0420, 8'h11, 8'hFF, 1'b1);
        wr(FSLP_CTL_ADDR, FSLP_CMD_PROTECT);
        rdc(FSLP_CTL_ADDR, 8'h04);
        wr(FSLP_PAGE_ADDR, 8'h02);
        wr(FSLP_CTL_ADDR, FSLP_CMD_RESET);
        unlock();
        prog(1, 13'h0430, 8'h00, 8'hFF, 1'b0);
        wr(FSLP_CTL_ADDR, FSLP_CMD_PAGE_ER);
        chk({15'h0, flash_page_erase_out}, 16'h0);
        chk({15'h0, op_refused_out}, 16'h1);
    endtask

    // a low enable freezes the program timer and ignores register writes
    task automatic s_freeze();
        int at;
        at = 0;
        wr(FSLP_PAGE_ADDR, 8'h04);
        @(posedge clk_in);
        flash_rdata_in <= 8'hFF;
        cpu_addr_in <= 13'h0800;
        cpu_data_in <= 8'h6C;
        program_memory_store_in <= 1'b1;
        @(posedge clk_in);
        program_memory_store_in <= 1'b0;
        en_in <= 1'b0;
        reg_addr_in <= FSLP_CTL_ADDR;
        reg_wdata_in <= FSLP_CMD_RESET;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        en_in <= 1'b1;
        #1;
        chk({15'h0, cpu_stall_out}, 16'h0001);
        // four frozen edges push the program pulse four cycles later
        for (int i = 1; i <= 24; i++) begin
            @(posedge clk_in);
            #1;
            if (flash_prog_out === 1'b1) begin
                at = i;
                chk({8'h00, flash_wdata_out}, 16'h006C);
                chk({3'h0, flash_addr_out}, 16'h0800);
            end
        end
        chk(16'(at), 16'h0014);
        rdc(FSLP_CTL_ADDR, 8'h01);
    endtask

    // a mid-run reset is the only way back to unprotected sectors
    task automatic s_second_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        wr(FSLP_CTL_ADDR, FSLP_CMD_PROTECT);
        rdc(FSLP_PAGE_ADDR, 8'h00);
    endtask
    // ***************************************************************
    // main sequence and watchdog
    // ***************************************************************
    initial begin
        rst_in = 1'b1;
        en_in = 1'b1;
        {reg_wr_in, reg_rd_in, dbg_wr_in} = 3'h0;
        {program_memory_store_in, program_memory_store_incr_in} = 2'h0;
        reg_addr_in = 12'h000;
        {reg_wdata_in, cpu_data_in, dbg_data_in} = 24'h0;
        flash_rdata_in = 8'hFF;
        cpu_addr_in = 13'h0000;
        dbg_addr_in = 13'h0000;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        s_reset_values();
        s_program();
        s_protect();
        s_freeze();
        s_second_reset();
        conclude();
    end

    // the full run takes well under 2000 cycles
    initial begin
        #50us;
        miscompares++;
        conclude();
    end
endmodule // fslp_top_tb_top
